// ==== cfg_pkg.sv ====
package cfg_pkg;
	// ****************************************
	// configuration space addresses
	// ****************************************
	localparam logic [15:0] USER_ID_BASE = 16'h8000;
	localparam logic [15:0] DEVICE_REVISION_ID_ADDR = 16'h8006;
	localparam logic [15:0] CONFIG_WORD_ONE_ADDR = 16'h8007;
	localparam logic [15:0] CONFIG_WORD_TWO_ADDR = 16'h8008;
	localparam int USER_ID_COUNT = 4;
	localparam int WORD_W = 14;
	// ****************************************
	// apb register map (byte addresses)
	// ****************************************
	localparam logic [11:0] REG_CONFIG_WORD_ONE = 12'h000;
	localparam logic [11:0] REG_CONFIG_WORD_TWO = 12'h004;
	localparam logic [11:0] REG_DEVICE_REVISION_ID = 12'h008;
	localparam logic [11:0] REG_USER_ID0 = 12'h010;
	localparam logic [11:0] REG_PROG_CTRL = 12'h020;
	localparam logic [11:0] REG_PROG_STATUS = 12'h024;
	localparam logic [11:0] REG_RUNTIME_CTRL = 12'h028;
	// prog_ctrl command codes in bits 1:0
	localparam logic [1:0] CMD_NONE = 2'h0;
	localparam logic [1:0] CMD_WRITE_ONE = 2'h1;
	localparam logic [1:0] CMD_WRITE_TWO = 2'h2;
	localparam logic [1:0] CMD_BULK_ERASE = 2'h3;
	// ****************************************
	// field positions, word one
	// ****************************************
	localparam int W1_CLOCK_OUT_PIN = 11;
	localparam int W1_BOREN_LO = 9;
	localparam int W1_CP = 7;
	localparam int W1_RESET_PIN_FUNCTION_SELECT = 6;
	localparam int W1_POWERUP_TIMER_ENABLE_N = 5;
	localparam int W1_WDTE_LO = 3;
	localparam int W1_FOSC_LO = 0;
	localparam logic [13:0] W1_IMPL_MASK = 14'h0efb;
	// ****************************************
	// field positions, word two
	// ****************************************
	localparam int W2_LVP = 13;
	localparam int W2_LOW_POWER_BROWNOUT_ENABLE_N = 11;
	localparam int W2_BROWNOUT_VOLTAGE_SELECT = 10;
	localparam int W2_STACK_FAULT_RESET_ENABLE = 9;
	localparam int W2_WRT_LO = 0;
	localparam logic [13:0] W2_IMPL_MASK = 14'h2e03;
	localparam logic [13:0] BLANK_WORD = 14'h3fff;
	// self-write protected upper bounds
	localparam logic [9:0] WRT_LIMIT_10 = 10'h0ff;
	localparam logic [9:0] WRT_LIMIT_01 = 10'h1ff;
	localparam logic [9:0] WRT_LIMIT_00 = 10'h3ff;
	// arbitrary neutral identity values
	localparam logic [8:0] DEVICE_ID_DEFAULT = 9'h0a5;
	localparam logic [4:0] REVISION_ID_DEFAULT = 5'h01;

	typedef enum logic [1:0] {
		MODE_OFF, MODE_SOFTWARE, MODE_RUN_ONLY, MODE_ON
	} enable_mode_t;
	typedef enum logic [1:0] {
		OSC_INTERNAL, OSC_EXT_LOW, OSC_EXT_MEDIUM, OSC_EXT_HIGH
	} osc_select_t;

	typedef struct packed {
		logic clock_out_active;
		logic brownout_active;
		logic powerup_timer_active;
		logic code_protect_active;
		logic reset_pin_is_reset;
		logic reset_pin_pullup;
		logic watchdog_active;
		osc_select_t osc_select;
		logic clock_in_is_io;
		logic low_voltage_prog_enable;
		logic low_power_brownout_active;
		logic brownout_low_trip;
		logic stack_fault_reset_enable;
		logic stack_circular;
		logic [1:0] self_write_protect_field;
	} settings_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic [9:0] addr;
	} mem_req_t;

	function automatic enable_mode_t decode_enable(input logic [1:0] f);
		return enable_mode_t'(f);
	endfunction

	function automatic logic mode_active(input enable_mode_t m, input logic sw_en, input logic sleeping);
		unique case (m)
			MODE_ON: return 1'b1;
			MODE_RUN_ONLY: return !sleeping;
			MODE_SOFTWARE: return sw_en;
			MODE_OFF: return 1'b0;
		endcase
	endfunction
endpackage

// ==== cfg_store.sv ====
`timescale 1ns/1ps
// non-volatile store for user id words and configuration words
module cfg_store import cfg_pkg::*; #(
	parameter int W = WORD_W
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// write side
	input wire logic we,
	input wire logic [2:0] waddr,
	input wire logic [W-1:0] wdata,
	input wire logic erase_all,
	// read side
	input wire logic [2:0] raddr,
	output logic [W-1:0] rdata
);
	// cells start blank and ignore reset: written words must survive it to be latched
	logic [W-1:0] mem_r [0:5] = '{default: {W{1'b1}}};
	logic [W-1:0] rdata_r;

	// erased cells read as all ones
	always_ff @(posedge pclk) begin
		if (erase_all) begin
			for (int i = 0; i < 6; i++) begin
				mem_r[i] <= {W{1'b1}};
			end
		end else if (we && waddr < 3'd6) begin
			mem_r[waddr] <= wdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_r <= {W{1'b1}};
		end else begin
			rdata_r <= (raddr < 3'd6) ? mem_r[raddr] : {W{1'b1}};
		end
	end
	assign rdata = rdata_r;
endmodule // cfg_store

// ==== cfg_decode.sv ====
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
module cfg_decode import cfg_pkg::*; #(
	parameter logic [8:0] DEVICE_ID = DEVICE_ID_DEFAULT,
	parameter logic [4:0] REVISION_ID = REVISION_ID_DEFAULT
) (
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// device state
	input wire logic sleeping,
	input wire logic prog_session_lvp,
	input wire logic port_pin3_pullup,
	// external programmer program memory access
	input wire mem_req_t ext_req,
	input wire logic [13:0] ext_mem_rdata,
	output logic [13:0] ext_rdata,
	output logic ext_write_allow,
	// internal cpu program memory writes
	input wire mem_req_t cpu_req,
	output logic cpu_write_allow,
	// decoded settings
	output settings_t settings
);
	// ****************************************
	// state
	// ****************************************
	typedef enum logic [1:0] {ST_LOAD_ONE, ST_LOAD_TWO, ST_LOAD_DONE, ST_RUN} load_state_t;

	typedef struct packed {
		load_state_t st;
		logic [13:0] word_one;
		logic [13:0] word_two;
		logic software_brownout_enable;
		logic software_watchdog_enable;
		logic rejected;
		logic reload;
		settings_t set;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic [13:0] ext_rdata;
		logic ext_write_allow;
		logic cpu_write_allow;
	} state_t;

	state_t s_r;
	state_t s_nxt;

	// store slots of the two words: user ids fill 0..3, the words follow in address order
	localparam logic [2:0] SLOT_WORD_ONE = 3'(CONFIG_WORD_ONE_ADDR - USER_ID_BASE - 16'h3);
	localparam logic [2:0] SLOT_WORD_TWO = 3'(CONFIG_WORD_TWO_ADDR - USER_ID_BASE - 16'h3);

	logic st_we;
	logic [2:0] st_waddr;
	logic [13:0] st_wdata;
	logic st_erase;
	logic [2:0] st_raddr;
	logic [13:0] st_rdata;

	cfg_store #(.W(WORD_W)) u_store (
		.pclk(pclk),
		.presetn(presetn),
		.we(st_we),
		.waddr(st_waddr),
		.wdata(st_wdata),
		.erase_all(st_erase),
		.raddr(st_raddr),
		.rdata(st_rdata)
	);

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [13:0] force_unimpl(input logic [13:0] w, input logic [13:0] mask);
		return w | ~mask;
	endfunction

	function automatic logic self_write_ok(input logic [1:0] f, input logic [9:0] a);
		unique case (f)
			2'b11: return 1'b1;
			2'b10: return a > WRT_LIMIT_10;
			2'b01: return a > WRT_LIMIT_01;
			2'b00: return a > WRT_LIMIT_00;
		endcase
	endfunction

	function automatic settings_t decode(input logic [13:0] w1, input logic [13:0] w2,
			input logic sbor, input logic swdt, input logic slp, input logic wpu);
		settings_t d;
		d.clock_out_active = !w1[W1_CLOCK_OUT_PIN];
		d.brownout_active = mode_active(decode_enable(w1[W1_BOREN_LO +: 2]), sbor, slp);
		d.powerup_timer_active = !w1[W1_POWERUP_TIMER_ENABLE_N];
		d.code_protect_active = !w1[W1_CP];
		d.low_voltage_prog_enable = w2[W2_LVP];
		if (w2[W2_LVP]) begin
			d.reset_pin_is_reset = 1'b1;
			d.reset_pin_pullup = 1'b1;
		end else begin
			d.reset_pin_is_reset = w1[W1_RESET_PIN_FUNCTION_SELECT];
			d.reset_pin_pullup = w1[W1_RESET_PIN_FUNCTION_SELECT] ? 1'b1 : wpu;
		end
		d.watchdog_active = mode_active(decode_enable(w1[W1_WDTE_LO +: 2]), swdt, slp);
		unique case (w1[W1_FOSC_LO +: 2])
			2'b11: d.osc_select = OSC_EXT_HIGH;
			2'b10: d.osc_select = OSC_EXT_MEDIUM;
			2'b01: d.osc_select = OSC_EXT_LOW;
			2'b00: d.osc_select = OSC_INTERNAL;
		endcase
		d.clock_in_is_io = (d.osc_select == OSC_INTERNAL);
		d.low_power_brownout_active = !w2[W2_LOW_POWER_BROWNOUT_ENABLE_N];
		d.brownout_low_trip = w2[W2_BROWNOUT_VOLTAGE_SELECT];
		d.stack_fault_reset_enable = w2[W2_STACK_FAULT_RESET_ENABLE];
		d.stack_circular = !w2[W2_STACK_FAULT_RESET_ENABLE];
		d.self_write_protect_field = w2[W2_WRT_LO +: 2];
		return d;
	endfunction

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		logic wr;
		logic [13:0] nw;
		wr = 1'b0;
		nw = '0;
		s_nxt = s_r;
		st_we = 1'b0;
		st_waddr = '0;
		st_wdata = '0;
		st_erase = 1'b0;
		st_raddr = SLOT_WORD_ONE;
		s_nxt.reload = 1'b0;

		// words are fetched from the store after reset, then frozen
		unique case (s_r.st)
			ST_LOAD_ONE: begin
				st_raddr = SLOT_WORD_ONE;
				s_nxt.st = ST_LOAD_TWO;
			end
			ST_LOAD_TWO: begin
				st_raddr = SLOT_WORD_TWO;
				s_nxt.word_one = force_unimpl(st_rdata, W1_IMPL_MASK);
				s_nxt.st = ST_LOAD_DONE;
			end
			ST_LOAD_DONE: begin
				s_nxt.word_two = force_unimpl(st_rdata, W2_IMPL_MASK);
				s_nxt.st = ST_RUN;
			end
			ST_RUN: ;
		endcase
		s_nxt.set = decode(s_r.word_one, s_r.word_two, s_r.software_brownout_enable,
			s_r.software_watchdog_enable, sleeping, port_pin3_pullup);

		// programmer access, protection from latched word one
		s_nxt.ext_rdata = s_r.set.code_protect_active ? 14'h0000 : ext_mem_rdata;
		s_nxt.ext_write_allow = ext_req.valid && ext_req.write && !s_r.set.code_protect_active;
		// cpu reads never gated; writes by self-write field only
		s_nxt.cpu_write_allow = cpu_req.valid && cpu_req.write &&
			self_write_ok(s_r.set.self_write_protect_field, cpu_req.addr);

		// apb: one wait state, answer in the second cycle after the setup
		s_nxt.pready = 1'b0;
		s_nxt.pslverr = 1'b0;
		if (psel && !penable) begin
			st_raddr = 3'(paddr[3:2]);
		end
		if (psel && penable && !s_r.pready) begin
			wr = pwrite;
			s_nxt.pready = 1'b1;
			s_nxt.prdata = '0;
			nw = pwdata[13:0];
			unique case (paddr)
				REG_CONFIG_WORD_ONE: s_nxt.prdata = {18'h0, s_r.word_one};
				REG_CONFIG_WORD_TWO: s_nxt.prdata = {18'h0, s_r.word_two};
				REG_DEVICE_REVISION_ID: s_nxt.prdata = {18'h0, DEVICE_ID, REVISION_ID};
				REG_USER_ID0, REG_USER_ID0 + 12'h4, REG_USER_ID0 + 12'h8, REG_USER_ID0 + 12'hc: begin
					s_nxt.prdata = {18'h0, st_rdata};
					if (wr) begin
						st_we = 1'b1;
						st_waddr = 3'(paddr[3:2]);
						st_wdata = nw;
					end
				end
				REG_PROG_CTRL: begin
					if (wr) begin
						unique case (pwdata[1:0])
							CMD_WRITE_ONE: begin
								// while protected, a word that would lift protection is refused; only erase lifts it
								st_we = !s_r.set.code_protect_active || !pwdata[16 + W1_CP];
								st_waddr = SLOT_WORD_ONE;
								st_wdata = force_unimpl(pwdata[29:16], W1_IMPL_MASK);
								s_nxt.rejected = !st_we;
							end
							CMD_WRITE_TWO: begin
								if (prog_session_lvp && !pwdata[16 + W2_LVP]) begin
									s_nxt.rejected = 1'b1;
								end else begin
									st_we = 1'b1;
									st_waddr = SLOT_WORD_TWO;
									st_wdata = force_unimpl(pwdata[29:16], W2_IMPL_MASK);
									s_nxt.rejected = 1'b0;
								end
							end
							CMD_BULK_ERASE: begin
								st_erase = 1'b1;
								s_nxt.rejected = 1'b0;
							end
							CMD_NONE: ;
						endcase
					end
				end
				REG_PROG_STATUS: begin
					s_nxt.prdata = {29'h0, s_r.set.code_protect_active, s_r.rejected, 1'b0};
					if (wr && pwdata[0]) begin
						s_nxt.rejected = 1'b0;
					end
				end
				REG_RUNTIME_CTRL: begin
					s_nxt.prdata = {30'h0, s_r.software_watchdog_enable, s_r.software_brownout_enable};
					if (wr) begin
						s_nxt.software_brownout_enable = pwdata[0];
						s_nxt.software_watchdog_enable = pwdata[1];
					end
				end
				default: s_nxt.pslverr = 1'b1;
			endcase
		end
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '{st: ST_LOAD_ONE, word_one: BLANK_WORD, word_two: BLANK_WORD,
				set: '0, default: '0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign prdata = s_r.prdata;
	assign pready = s_r.pready;
	assign pslverr = s_r.pslverr;
	assign ext_rdata = s_r.ext_rdata;
	assign ext_write_allow = s_r.ext_write_allow;
	assign cpu_write_allow = s_r.cpu_write_allow;
	assign settings = s_r.set;
endmodule // cfg_decode

// ==== cfg_decode_properties.sv ====
`timescale 1ns/1ps
module cfg_decode_checker import cfg_pkg::*; (
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	// memory access
	input wire mem_req_t ext_req,
	input wire logic [13:0] ext_mem_rdata,
	input wire logic [13:0] ext_rdata,
	input wire logic ext_write_allow,
	input wire mem_req_t cpu_req,
	input wire logic cpu_write_allow,
	// decoded settings
	input wire settings_t settings
);
	// ****
	// settle counter: decoded settings are blank for one cycle after reset
	// ****
	logic [3:0] up_r;
	wire logic [1:0] wf = settings.self_write_protect_field;
	wire logic wr_ok = wf == 2'h3 || (wf == 2'h2 && cpu_req.addr > WRT_LIMIT_10) || (wf == 2'h1 && cpu_req.addr > WRT_LIMIT_01);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) up_r <= 4'h0;
		else if (up_r != 4'hf) up_r <= up_r + 4'h1;
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_one_wait: assert property (psel && penable && !pready |=> pready)
		else $error("no answer one cycle after access");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_prot_read: assert property (ext_req.valid && !ext_req.write && settings.code_protect_active |=> ext_rdata == 14'h0)
		else $error("protected read not zero");
	a_open_read: assert property (ext_req.valid && !ext_req.write && !settings.code_protect_active |=> ext_rdata == $past(ext_mem_rdata))
		else $error("open read data wrong");
	a_ext_write: assert property (ext_req.valid && ext_req.write |=> ext_write_allow == !$past(settings.code_protect_active))
		else $error("external write permission wrong");
	a_self_write: assert property (cpu_req.valid && cpu_req.write |=> cpu_write_allow == $past(wr_ok))
		else $error("self write permission wrong");
	a_lvp_pin: assert property (settings.low_voltage_prog_enable |-> settings.reset_pin_is_reset && settings.reset_pin_pullup)
		else $error("reset pin not reset under lvp");
	a_stack_mode: assert property (up_r > 4'h1 |-> settings.stack_circular != settings.stack_fault_reset_enable)
		else $error("stack mode wrong");
	a_clk_in_io: assert property (up_r > 4'h1 |-> settings.clock_in_is_io == (settings.osc_select == OSC_INTERNAL))
		else $error("clock-in pin use wrong");
	a_held_run: assert property (up_r == 4'hf |-> $stable({settings.code_protect_active, settings.osc_select}))
		else $error("latched settings changed");
	c_prot_read: cover property (ext_req.valid && !ext_req.write && settings.code_protect_active);
	c_apb_err: cover property (pslverr);
	c_cpu_ok: cover property (cpu_write_allow);
endmodule // cfg_decode_checker
bind cfg_decode cfg_decode_checker u_cfg_decode_checker (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
	.ext_req, .ext_mem_rdata, .ext_rdata, .ext_write_allow, .cpu_req, .cpu_write_allow, .settings);

// ==== prog_model.sv ====
`timescale 1ns/1ps
module prog_model import cfg_pkg::*; (
	// clock
	input wire logic pclk,
	// to the device
	output mem_req_t ext_req,
	output logic [13:0] ext_mem_rdata,
	// from the device
	input wire logic [13:0] ext_rdata,
	input wire logic ext_write_allow
);
	// ****
	// raw flash data moves every cycle so a stale capture cannot pass
	// ****
	initial ext_req = '0;
	initial ext_mem_rdata = 14'h1555;
	always @(posedge pclk) ext_mem_rdata <= {ext_mem_rdata[12:0], ext_mem_rdata[13] ^ ext_mem_rdata[10]};
	task access(input logic w, input logic [9:0] a, output logic [13:0] seen, output logic [13:0] got, output logic ok);
		@(posedge pclk);
		ext_req <= '{1'b1, w, a};
		@(posedge pclk);
		seen = ext_mem_rdata;
		ext_req <= '{1'b0, 1'b0, ~a};
		#1 got = ext_rdata;
		ok = ext_write_allow;
	endtask
endmodule // prog_model

// ==== config_word_protection_decode_test.sv ====
`timescale 1ns/1ps
module config_word_protection_decode_test import cfg_pkg::*;;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sleeping = 0, lvs = 0, wpu = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd, x = 32'h583a;
	logic pready, pslverr, er, ewa, cwa;
	mem_req_t ext_req, cpu_req = '0;
	logic [13:0] emd, erd;
	settings_t settings;
	int n_mismatch = 0, compares = 0;
	cfg_decode u_cfg_decode (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.sleeping, .prog_session_lvp(lvs), .port_pin3_pullup(wpu), .ext_req, .ext_mem_rdata(emd), .ext_rdata(erd),
		.ext_write_allow(ewa), .cpu_req, .cpu_write_allow(cwa), .settings);
	prog_model u_prog_model (.pclk, .ext_req, .ext_mem_rdata(emd), .ext_rdata(erd), .ext_write_allow(ewa));
	initial forever #5 pclk = ~pclk;
	// ****
	// helpers
	// ****
	function logic [31:0] rnd;
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	function logic act(logic [1:0] f, logic sw, logic slp);
		return f == 2'h3 ? 1'b1 : f == 2'h2 ? !slp : f == 2'h1 ? sw : 1'b0;
	endfunction
	function automatic settings_t exp_set(logic [13:0] a, b, logic slp, sb, sw, pu);
		settings_t s;
		s.clock_out_active = !a[11];
		s.brownout_active = act(a[10:9], sb, slp);
		s.powerup_timer_active = !a[5];
		s.code_protect_active = !a[7];
		s.reset_pin_is_reset = b[13] | a[6];
		s.reset_pin_pullup = b[13] | a[6] | pu;
		s.watchdog_active = act(a[4:3], sw, slp);
		s.osc_select = osc_select_t'(a[1:0]);
		s.clock_in_is_io = a[1:0] == 2'h0;
		s.low_voltage_prog_enable = b[13];
		s.low_power_brownout_active = !b[11];
		s.brownout_low_trip = b[10];
		s.stack_fault_reset_enable = b[9];
		s.stack_circular = !b[9];
		s.self_write_protect_field = b[1:0];
		return s;
	endfunction
	task chk(input logic [31:0] g, e, input string m);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %0t %s", $time, m);
		end
	endtask
	task conclude;
		$display("counts: %0d compares, %0d mismatches", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) chk(0, 1, "apb timeout");
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task cmd(input logic [1:0] c, input logic [13:0] d);
		apb(1, REG_PROG_CTRL, {2'h0, d, 14'h0, c});
	endtask
	task rst;
		presetn <= 0;
		repeat (2) @(posedge pclk);
		presetn <= 1;
		repeat (4) @(posedge pclk);
	endtask
	task cpu(input logic [9:0] a, input logic [1:0] f);
		@(posedge pclk);
		cpu_req <= '{1'b1, 1'b1, a};
		@(posedge pclk);
		cpu_req <= '0;
		#1 chk(cwa, f == 2'h3 || (f == 2'h2 && a > WRT_LIMIT_10) || (f == 2'h1 && a > WRT_LIMIT_01), "cpu write");
	endtask
	initial begin
		#200000;
		n_mismatch++;
		conclude();
	end
	// ****
	// main sequence
	// ****
	initial begin
		int i;
		logic [13:0] w1, w2, s, g;
		logic ok, cp, rej;
		logic [31:0] d;
		logic [9:0] adr [4] = '{10'h0ff, 10'h100, 10'h1ff, 10'h200};
		repeat (12) @(posedge pclk);
		presetn <= 1;
		repeat (4) @(posedge pclk);
		apb(0, REG_CONFIG_WORD_ONE, 0);
		chk(rd[13:0], BLANK_WORD, "blank one");
		apb(0, REG_CONFIG_WORD_TWO, 0);
		chk(rd[13:0], BLANK_WORD, "blank two");
		apb(0, REG_DEVICE_REVISION_ID, 0);
		chk(rd[13:0], {DEVICE_ID_DEFAULT, REVISION_ID_DEFAULT}, "id word");
		apb(0, 12'h0fc, 0);
		chk(er, 1, "unmapped");
		for (i = 0; i < 4; i++) begin
			d = rnd();
			apb(1, REG_USER_ID0 + 12'(4 * i), d);
			apb(0, REG_USER_ID0 + 12'(4 * i), 0);
			chk(rd[13:0], d[13:0], "user id");
		end
		$display("test blank done");
		for (i = 0; i < 12; i++) begin
			d = rnd();
			w1 = i == 0 ? 14'h0 : i == 1 ? 14'h3fff : d[13:0];
			w2 = i == 0 ? 14'h0 : i == 1 ? 14'h3fff : d[27:14];
			w1[10:9] = i[1:0];
			w1[4:3] = ~i[1:0];
			w1[1:0] = i[1:0];
			w2[1:0] = i[2:1];
			lvs <= d[31];
			rej = d[31] & !w2[13];
			cmd(CMD_BULK_ERASE, 0);
			cmd(CMD_WRITE_ONE, w1);
			cmd(CMD_WRITE_TWO, w2);
			apb(0, REG_PROG_STATUS, 0);
			chk(rd[1], rej, "lvp refusal");
			apb(1, REG_PROG_STATUS, 1);
			rst();
			w1 |= ~W1_IMPL_MASK;
			w2 = rej ? BLANK_WORD : w2 | ~W2_IMPL_MASK;
			cp = !w1[7];
			apb(0, REG_CONFIG_WORD_ONE, 0);
			chk(rd[13:0], w1, "word one");
			apb(0, REG_CONFIG_WORD_TWO, 0);
			chk(rd[13:0], w2, "word two");
			apb(0, REG_PROG_STATUS, 0);
			chk(rd[2], cp, "protect flag");
			repeat (2) begin
				d = rnd();
				sleeping <= d[0];
				wpu <= d[1];
				apb(1, REG_RUNTIME_CTRL, {30'h0, d[3:2]});
				repeat (2) @(posedge pclk);
				chk(settings, exp_set(w1, w2, d[0], d[2], d[3], d[1]), "settings");
			end
			u_prog_model.access(0, d[13:4], s, g, ok);
			chk(g, cp ? 14'h0 : s, "ext read");
			u_prog_model.access(1, d[13:4], s, g, ok);
			chk(ok, !cp, "ext write");
			foreach (adr[k]) cpu(adr[k], w2[1:0]);
			cpu(d[23:14], w2[1:0]);
			if (cp) begin
				cmd(CMD_WRITE_ONE, BLANK_WORD);
				apb(0, REG_PROG_STATUS, 0);
				chk(rd[1], 1, "protected write refused");
				rst();
				apb(0, REG_CONFIG_WORD_ONE, 0);
				chk(rd[7], 0, "protect kept");
				cmd(CMD_BULK_ERASE, 0);
				rst();
				apb(0, REG_CONFIG_WORD_ONE, 0);
				chk(rd[13:0], BLANK_WORD, "erased");
			end
			$display("test round %0d done", i);
		end
		conclude();
	end
endmodule // config_word_protection_decode_test
